// File: hw/gpio_consts.svh
// Register map, field codes, reset values and masks of the GPIO port block
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ------------------------------------------------------------
// Register indices (byte address = index * 4)
// ------------------------------------------------------------
`define GP_ADDR_W      14
`define GP_BASE_A      12'hFD0
`define GP_BASE_B      12'hFD4
`define GP_BASE_C      12'hFD8
`define GP_OFS_INDEX   2'h0
`define GP_OFS_WINDOW  2'h1
`define GP_OFS_INPUT   2'h2
`define GP_OFS_OUTPUT  2'h3
`define GP_IRQ_STAT    12'hFE0
`define GP_IRQ_MASK    12'hFE1
`define GP_EDGE_SEL    12'hFE2

// ------------------------------------------------------------
// Sub-register select codes
// ------------------------------------------------------------
`define GP_SEL_DIR     8'h01
`define GP_SEL_ALT     8'h02
`define GP_SEL_OD      8'h03
`define GP_SEL_HDE     8'h04
`define GP_SEL_WAKE    8'h05
`define GP_SEL_PULL    8'h06

// ------------------------------------------------------------
// Reset values and implemented-pin masks
// ------------------------------------------------------------
`define GP_IDX_RST     8'h00
`define GP_DIR_RST     8'hFF
`define GP_CFG_RST     8'h00
`define GP_OUT_RST     8'h00
`define GP_IRQ_RST     24'h00_0000
`define GP_IMPL_A      8'hFF
`define GP_IMPL_B_SM   8'h03
`define GP_IMPL_C_SM   8'h01
`define GP_IMPL_B_LG   8'h1F
`define GP_IMPL_C_LG   8'h3F
`define GP_AUTO_OD_A   8'hC0
`define GP_NO_AUTO_OD  8'h00

`endif

// File: hw/gpio_pkg.sv
// Types shared by the GPIO port block
package gpio_pkg;

  // Per-port configuration sub-registers
  typedef struct packed {
    logic [7:0] dd;
    logic [7:0] af;
    logic [7:0] oc;
    logic [7:0] hde;
    logic [7:0] smre;
    logic [7:0] pue;
  } port_cfg_t;

  // Pin value with its output enable
  typedef struct packed {
    logic [7:0] val;
    logic [7:0] oe;
  } pin_drive_t;

endpackage

// File: hw/gpio_port.sv
// One GPIO port: index, configuration sub-registers, data, pin drive, input sync
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_port #(
  parameter logic [7:0] IMPL       = 8'hFF,
  parameter logic [7:0] AUTO_OD    = 8'h00,
  parameter bit         BOTH_EDGES = 1'b0
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // Register strobes from the bus slave
  input  wire logic                 wrIndex,
  input  wire logic                 wrWindow,
  input  wire logic                 wrOutput,
  input  wire logic [7:0]           wrData,
  input  wire logic [7:0]           edgeFall,
  output logic [7:0]                indexVal,
  output logic [7:0]                windowVal,
  output logic [7:0]                inputVal,
  output logic [7:0]                outputVal,
  output gpio_pkg::port_cfg_t       cfg,
  // Pads and peripherals
  input  wire logic [7:0]           padIn,
  output gpio_pkg::pin_drive_t      padDrive,
  input  wire gpio_pkg::pin_drive_t altDrive,
  output logic [7:0]                altIn,
  output logic [7:0]                edgeEvent
);

  logic [7:0]          idx_q, idx_d, out_q, out_d;
  logic [7:0]          s1_q, s2_q, s3_q, in_q, in_d;
  logic [7:0]          agree, value, enable, openDrain, change, polarity;
  gpio_pkg::port_cfg_t cfg_q, cfg_d;

  // Next state: each configuration bit has its own pin position
  always_comb begin
    idx_d = idx_q;
    out_d = out_q;
    cfg_d = cfg_q;
    if (wrIndex) begin
      idx_d = wrData;
    end
    if (wrOutput) begin
      out_d = wrData & IMPL;
    end
    if (wrWindow) begin
      case (idx_q)
        `GP_SEL_DIR:  cfg_d.dd   = wrData & IMPL;
        `GP_SEL_ALT:  cfg_d.af   = wrData & IMPL;
        `GP_SEL_OD:   cfg_d.oc   = wrData & IMPL;
        `GP_SEL_HDE:  cfg_d.hde  = wrData & IMPL;
        `GP_SEL_WAKE: cfg_d.smre = wrData & IMPL;
        `GP_SEL_PULL: cfg_d.pue  = wrData & IMPL;
        default:      cfg_d      = cfg_q;
      endcase
    end
    // Input changes once the second and third stages agree
    agree = ~(s2_q ^ s3_q);
    in_d  = (agree & s2_q) | (~agree & in_q);
  end

  // Registers; unimplemented pins stay zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      idx_q   <= `GP_IDX_RST;
      out_q   <= `GP_OUT_RST;
      cfg_q   <= '{dd: `GP_DIR_RST & IMPL, default: `GP_CFG_RST};
      s1_q    <= 8'h00;
      s2_q    <= 8'h00;
      s3_q    <= 8'h00;
      in_q    <= 8'h00;
    end else begin
      idx_q   <= idx_d;
      out_q   <= out_d;
      cfg_q   <= cfg_d;
      s1_q    <= padIn;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      in_q    <= in_d & IMPL;
    end
  end

  // Window read: unselected codes return zero
  always_comb begin
    case (idx_q)
      `GP_SEL_DIR:  windowVal = cfg_q.dd;
      `GP_SEL_ALT:  windowVal = cfg_q.af;
      `GP_SEL_OD:   windowVal = cfg_q.oc;
      `GP_SEL_HDE:  windowVal = cfg_q.hde;
      `GP_SEL_WAKE: windowVal = cfg_q.smre;
      `GP_SEL_PULL: windowVal = cfg_q.pue;
      default:      windowVal = 8'h00;
    endcase
  end

  // Pad drive: peripheral owns direction in alternate mode; open drain drops the high side
  assign value        = (cfg_q.af & altDrive.val) | (~cfg_q.af & out_q);
  assign enable       = (cfg_q.af & altDrive.oe) | (~cfg_q.af & ~cfg_q.dd);
  assign openDrain    = cfg_q.oc | (AUTO_OD & cfg_q.af);
  assign padDrive.val = value & IMPL;
  assign padDrive.oe  = enable & ~(openDrain & value) & IMPL;

  // Edge events from the filtered input
  assign change    = (in_d & IMPL) ^ in_q;
  assign polarity  = (edgeFall & ~in_d) | (~edgeFall & in_d);
  assign edgeEvent = BOTH_EDGES ? change : (change & polarity);

  assign indexVal  = idx_q;
  assign outputVal = out_q;
  assign inputVal  = in_q;
  assign altIn     = in_q;
  assign cfg       = cfg_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_dir_reset: assert property ($past(sys_rst) |-> cfg_q.dd == (`GP_DIR_RST & IMPL))
    else $error("direction bits not reset to input");
  a_pad_drives_out: assert property (
    ((padDrive.oe ^ (IMPL & ~cfg_q.af & ~cfg_q.dd & ~cfg_q.oc)) & (IMPL & ~cfg_q.af & ~cfg_q.dd & ~cfg_q.oc)) == 8'h00
    && ((padDrive.val ^ out_q) & ~cfg_q.af & IMPL) == 8'h00)
    else $error("output pin not driven from output value");
  a_od_no_high: assert property ((padDrive.oe & padDrive.val & cfg_q.oc) == 8'h00)
    else $error("open-drain pin driven high");
  a_auto_od: assert property ((padDrive.oe & padDrive.val & cfg_q.af & AUTO_OD) == 8'h00)
    else $error("auto open-drain pin driven high");
  // A pad level reaches the input register three edges after it is sampled, and only once it has held for two
  a_input_sync: assert property (
    $past(sys_rst) == 1'b0 && $changed(in_q)
    |-> ((in_q ^ $past(padIn, 3)) & (in_q ^ $past(in_q))) == 8'h00
     && ((in_q ^ $past(padIn, 4)) & (in_q ^ $past(in_q))) == 8'h00)
    else $error("input changed without three-stage agreement");

endmodule // gpio_port

// File: hw/gpio_ports_indirect_config.sv
// GPIO block of three ports with indirect configuration, Avalon-MM slave and edge interrupts
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "gpio_consts.svh"

// Overview of operation
// - Up to nineteen I/O pins across ports A, B and C.
// - Every pin configures on its own bit in each sub-register.
// - Pin widths per variant: small A8 B2 C1, large A8 B5 C6.
// - Alternate-function pins take direction from their peripheral.
// - A: timers, UART, I2C; B: analog inputs 0-4; C: timer 1 and SPI.
// - Port A bits 6 and 7 are open drain in alternate mode.
// - Port A and C pins request interrupts on the selected edge, port B pins on both edges.
// - Each port has index, window, input and output registers.
// - Window accesses reach the sub-register chosen by the index.
// - Codes 01H to 06H select direction, alternate, drain, drive, wake, pull-up.
// - Index 00H and 07H to FFH select nothing; reset is 00H.
// - Index registers at FD0H, FD4H, FD8H, read/write, reset 00H.
// - Window registers at FD1H, FD5H, FD9H, read/write, routed by index.
// - Direction 0 drives output value; 1 tri-states and samples; resets 1.
// - Alternate bit 1 hands pin to peripheral; resets 0.
// - Drain bit 1 removes high drive, also in alternate mode; resets 0.
module gpio_ports_indirect_config #(
  parameter bit LARGE = 1'b1
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  // Avalon-MM slave
  input  wire logic [`GP_ADDR_W-1:0]     address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  input  wire logic [3:0]                byteenable,
  output logic [31:0]                    readdata,
  output logic                           waitrequest,
  // Interrupt
  output logic                           irq,
  // Pads, index 0 = port A, 1 = B, 2 = C
  input  wire logic [2:0][7:0]           padIn,
  output gpio_pkg::pin_drive_t [2:0]     padDrive,
  output gpio_pkg::port_cfg_t [2:0]      portCfg,
  // Peripheral side of alternate functions
  input  wire gpio_pkg::pin_drive_t [2:0] altDrive,
  output logic [2:0][7:0]                altIn
);

  // ------------------------------------------------------------
  // Port shape
  // ------------------------------------------------------------
  // Alternate mapping by pin: A0/A1 timer 0 in/out, A2 UART driver enable,
  // A3 clear to send, A4 receive, A5 transmit, A6/A7 I2C clock/data;
  // B0..B4 analog inputs 0..4; C0/C1 timer 1 in/out, C2..C5 SPI
  localparam logic [2:0][7:0]  IMPL_MASK = LARGE ? {`GP_IMPL_C_LG, `GP_IMPL_B_LG, `GP_IMPL_A}
                                                 : {`GP_IMPL_C_SM, `GP_IMPL_B_SM, `GP_IMPL_A};
  localparam logic [2:0][7:0]  AUTO_OD   = {`GP_NO_AUTO_OD, `GP_NO_AUTO_OD, `GP_AUTO_OD_A};
  localparam logic [2:0][11:0] PORT_BASE = {`GP_BASE_C, `GP_BASE_B, `GP_BASE_A};

  logic [11:0]      regIdx;
  logic             wrEn;
  logic [2:0]       wrIndex, wrWindow, wrOutput;
  logic [2:0][7:0]  indexVal, windowVal, inputVal, outputVal, edgeEvent;
  logic [23:0]      events, clearBits, stat_q, stat_d, mask_q, mask_d, edge_q, edge_d;
  logic             ack_q, ack_d;
  logic [31:0]      rd_q, rd_d;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  // One wait state: the request is seen, the answer is registered, then released
  assign regIdx      = address[`GP_ADDR_W-1:2];
  assign waitrequest = (read | write) & ~ack_q;
  assign wrEn        = write & ack_q;
  assign readdata    = rd_q;

  // ------------------------------------------------------------
  // Ports
  // ------------------------------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_port
    logic hit;
    assign hit         = regIdx[11:2] == PORT_BASE[p][11:2];
    assign wrIndex[p]  = wrEn & byteenable[0] & hit & (regIdx[1:0] == `GP_OFS_INDEX);
    assign wrWindow[p] = wrEn & byteenable[0] & hit & (regIdx[1:0] == `GP_OFS_WINDOW);
    assign wrOutput[p] = wrEn & byteenable[0] & hit & (regIdx[1:0] == `GP_OFS_OUTPUT);

    gpio_port #(
      .IMPL       (IMPL_MASK[p]),
      .AUTO_OD    (AUTO_OD[p]),
      .BOTH_EDGES (p == 1)
    ) u_port (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .wrIndex    (wrIndex[p]),
      .wrWindow   (wrWindow[p]),
      .wrOutput   (wrOutput[p]),
      .wrData     (writedata[7:0]),
      .edgeFall   (edge_q[8*p +: 8]),
      .indexVal   (indexVal[p]),
      .windowVal  (windowVal[p]),
      .inputVal   (inputVal[p]),
      .outputVal  (outputVal[p]),
      .cfg        (portCfg[p]),
      .padIn      (padIn[p]),
      .padDrive   (padDrive[p]),
      .altDrive   (altDrive[p]),
      .altIn      (altIn[p]),
      .edgeEvent  (edgeEvent[p])
    );
  end

  // ------------------------------------------------------------
  // Interrupt and edge-select registers
  // ------------------------------------------------------------
  assign events = {edgeEvent[2], edgeEvent[1], edgeEvent[0]};

  // Write-one-to-clear; a new event in the same cycle keeps its bit
  always_comb begin
    clearBits = 24'h00_0000;
    mask_d    = mask_q;
    edge_d    = edge_q;
    for (int b = 0; b < 3; b++) begin
      if (wrEn && byteenable[b] && regIdx == `GP_IRQ_STAT) begin
        clearBits[8*b +: 8] = writedata[8*b +: 8];
      end
      if (wrEn && byteenable[b] && regIdx == `GP_IRQ_MASK) begin
        mask_d[8*b +: 8] = writedata[8*b +: 8];
      end
      if (wrEn && byteenable[b] && regIdx == `GP_EDGE_SEL) begin
        edge_d[8*b +: 8] = writedata[8*b +: 8];
      end
    end
    stat_d = (stat_q & ~clearBits) | events;
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Unmapped words read zero and ignore writes, but still answer
  always_comb begin
    rd_d = 32'h0000_0000;
    for (int p = 0; p < 3; p++) begin
      if (regIdx[11:2] == PORT_BASE[p][11:2]) begin
        unique case (regIdx[1:0])
          `GP_OFS_INDEX:  rd_d[7:0] = indexVal[p];
          `GP_OFS_WINDOW: rd_d[7:0] = windowVal[p];
          `GP_OFS_INPUT:  rd_d[7:0] = inputVal[p];
          `GP_OFS_OUTPUT: rd_d[7:0] = outputVal[p];
        endcase
      end
    end
    if (regIdx == `GP_IRQ_STAT) begin
      rd_d[23:0] = stat_q;
    end
    if (regIdx == `GP_IRQ_MASK) begin
      rd_d[23:0] = mask_q;
    end
    if (regIdx == `GP_EDGE_SEL) begin
      rd_d[23:0] = edge_q;
    end
    ack_d = (read | write) & ~ack_q;
  end

  // Register everything; read data is captured during the wait state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_q  <= 1'b0;
      rd_q   <= 32'h0000_0000;
      stat_q <= `GP_IRQ_RST;
      mask_q <= `GP_IRQ_RST;
      edge_q <= `GP_IRQ_RST;
    end else begin
      ack_q  <= ack_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      edge_q <= edge_d;
      if (read && !ack_q) begin
        rd_q <= rd_d;
      end
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(stat_q & mask_q);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_index_reset: assert property ($past(sys_rst) |-> indexVal == 24'h00_0000)
    else $error("index registers not reset to zero");
  a_index_write: assert property (wrIndex[0] |=> indexVal[0] == $past(writedata[7:0]))
    else $error("index write not stored");
  a_window_idle: assert property (
    read && !waitrequest && regIdx == (`GP_BASE_A | 12'h001) && (indexVal[0] == 8'h00 || indexVal[0] > `GP_SEL_PULL)
    |-> readdata == 32'h0000_0000)
    else $error("unselected window did not read zero");
  a_window_route: assert property (
    read && !waitrequest && regIdx == (`GP_BASE_A | 12'h001) && indexVal[0] == `GP_SEL_DIR
    |-> readdata[7:0] == portCfg[0].dd)
    else $error("window read not routed to direction bits");
  a_window_drain: assert property (
    wrWindow[0] && indexVal[0] == `GP_SEL_OD |=> portCfg[0].oc == ($past(writedata[7:0]) & `GP_IMPL_A))
    else $error("drain code did not reach drain bits");
  a_window_ignore: assert property (
    wrWindow[1] && indexVal[1] == 8'h00 |=> $stable(portCfg[1]))
    else $error("window write with no selection changed config");
  a_event_sticky: assert property ((|events) |=> (stat_q & $past(events)) == $past(events))
    else $error("edge event lost from status");
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not after one wait state");

  c_irq_raised:   cover property ($rose(irq));
  c_dir_written:  cover property (wrWindow[0] && indexVal[0] == `GP_SEL_DIR);
  c_alt_mode:     cover property (portCfg[0].af[6] && altDrive[0].oe[6]);

endmodule // gpio_ports_indirect_config

// File: verification/pin_partner.sv
// External circuitry on the GPIO pads: drivers, pull-ups and floating lines
`timescale 1ns/1ps
module pin_partner (
  // Clock
  input  wire logic                       ref_clk,
  // Device side of the pads
  input  wire gpio_pkg::pin_drive_t [2:0] padDrive,
  input  wire gpio_pkg::port_cfg_t [2:0]  portCfg,
  // External drivers set by the bench
  input  wire logic [2:0][7:0]            extVal,
  input  wire logic [2:0][7:0]            extEn,
  // Resolved pad levels
  output logic [2:0][7:0]                 padIn
);
  // ----------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------
  logic [2:0][7:0] floatQ = '0;

  // A line nobody holds wanders, so a stale level is never trusted
  always_ff @(posedge ref_clk) begin
    floatQ <= ~floatQ;
  end

  // Device driver first, then the outside driver, then the pull-up
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 8; i++) begin
        if (padDrive[p].oe[i]) padIn[p][i] = padDrive[p].val[i];
        else if (extEn[p][i]) padIn[p][i] = extVal[p][i];
        else if (portCfg[p].pue[i]) padIn[p][i] = 1'b1;
        else padIn[p][i] = floatQ[p][i];
      end
    end
  end
endmodule // pin_partner

// File: verification/tb_gpio_ports_indirect_config.sv
// Self-checking bench for the three-port GPIO block with indirect configuration
`timescale 1ns/1ps
`include "gpio_consts.svh"
module tb_gpio_ports_indirect_config;
  // ----------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------
  localparam logic [11:0] BASE [3] = '{`GP_BASE_A, `GP_BASE_B, `GP_BASE_C};
  localparam logic [7:0]  IMPL [3] = '{`GP_IMPL_A, `GP_IMPL_B_LG, `GP_IMPL_C_LG};
  localparam logic [7:0]  NOSEL [3] = '{8'h00, 8'h07, 8'hFF};
  logic                       ref_clk;
  logic                       sys_rst;
  logic [`GP_ADDR_W-1:0]      address;
  logic                       read;
  logic                       write;
  logic [31:0]                writedata;
  logic [31:0]                readdata;
  logic                       waitrequest;
  logic                       irq;
  logic [2:0][7:0]            padIn;
  logic [2:0][7:0]            extVal;
  logic [2:0][7:0]            altIn;
  gpio_pkg::pin_drive_t [2:0] padDrive;
  gpio_pkg::pin_drive_t [2:0] altDrive;
  gpio_pkg::port_cfg_t [2:0]  portCfg;
  logic [31:0]                expQ [$];
  logic [31:0]                seed;
  int                         nFail = 0;
  int                         totalChecks = 0;
  int                         cycles = 0;

  // ----------------------------------------------------------
  // Design and pad partner
  // ----------------------------------------------------------
  gpio_ports_indirect_config #(.LARGE(1'b1)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .padIn(padIn), .padDrive(padDrive), .portCfg(portCfg), .altDrive(altDrive), .altIn(altIn));
  pin_partner partner_u (.ref_clk(ref_clk), .padDrive(padDrive), .portCfg(portCfg), .extVal(extVal),
    .extEn(24'hFFFFFF), .padIn(padIn));

  // Free-running clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    totalChecks++;
    if (seen !== want) begin
      nFail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Xorshift step; the low bytes feed pad and register values
  function automatic void nx();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endfunction

  // One Avalon access held until waitrequest is sampled low; returns one rising edge later with results settled
  // A hung slave is ended by the bench timeout only, so no local limit here
  task automatic acc(input bit wr, input logic [11:0] wa, input logic [31:0] wd, input logic [31:0] ex);
    if (!wr) expQ.push_back(ex);
    @(posedge ref_clk);
    address <= {wa, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= wd;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Choose a sub-register and write it through the window
  task automatic sel(input int p, input logic [7:0] c, input logic [7:0] v);
    acc(1'b1, BASE[p], {24'h0, c}, 32'h0);
    acc(1'b1, BASE[p] + 12'h001, {24'h0, v}, 32'h0);
  endtask

  // Read results are compared at the edge where the slave answers
  always @(posedge ref_clk) begin
    cycles++;
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (expQ.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
      else chk(readdata, expQ.pop_front());
    end
    if (cycles == 20000) begin
      nFail++;
      $display("ERROR %0t timeout", $time);
      conclude();
    end
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] o;
    logic [7:0] a;
    logic [7:0] m;
    logic [23:0] e;
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    extVal = '0;
    altDrive = '0;
    seed = 32'h0000_0053;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Reset values, then every select code with a random pattern per port
    for (int p = 0; p < 3; p++) begin
      acc(1'b0, BASE[p], 32'h0, 32'h0);
      acc(1'b0, BASE[p] + 12'h001, 32'h0, 32'h0);
      acc(1'b1, BASE[p], 32'h1, 32'h0);
      acc(1'b0, BASE[p] + 12'h001, 32'h0, {24'h0, IMPL[p]});
      for (int c = 1; c < 7; c++) begin
        nx();
        v = seed[7:0];
        sel(p, 8'(c), v);
        acc(1'b0, BASE[p] + 12'h001, 32'h0, {24'h0, v & IMPL[p]});
        chk({24'h0, portCfg[p][8*(6-c) +: 8]}, {24'h0, v & IMPL[p]});
      end
      foreach (NOSEL[k]) begin
        sel(p, NOSEL[k], 8'hA5);
        acc(1'b0, BASE[p] + 12'h001, 32'h0, 32'h0);
      end
      acc(1'b1, BASE[p], 32'h6, 32'h0);
      acc(1'b0, BASE[p] + 12'h001, 32'h0, {24'h0, v & IMPL[p]});
      sel(p, 8'h02, 8'h00);
      sel(p, 8'h03, 8'h00);
      sel(p, 8'h01, 8'hFF);
    end
    // Port A as output, then open drain, then handed to its peripheral
    nx();
    o = seed[7:0];
    sel(0, 8'h01, 8'h00);
    acc(1'b1, BASE[0] + 12'h003, {24'h0, o}, 32'h0);
    chk({16'h0, padDrive[0].oe, padDrive[0].val}, {16'h0, 8'hFF, o});
    repeat (6) @(posedge ref_clk);
    acc(1'b0, BASE[0] + 12'h002, 32'h0, {24'h0, o});
    sel(0, 8'h03, 8'h0F);
    chk({16'h0, padDrive[0].oe}, {24'h0, ~(8'h0F & o)});
    nx();
    a = seed[7:0] | 8'hC0;
    m = seed[15:8];
    altDrive[0] <= {a, m};
    sel(0, 8'h02, 8'hFF);
    chk({16'h0, padDrive[0].oe, padDrive[0].val}, {16'h0, m & ~((8'h0F | `GP_AUTO_OD_A) & a), a});
    sel(0, 8'h02, 8'h00);
    sel(0, 8'h03, 8'h00);
    sel(0, 8'h01, 8'hFF);
    chk({24'h0, padDrive[0].oe}, 32'h0);
    // Pads sampled into the read-only input registers
    nx();
    e = seed[23:0];
    extVal <= e;
    repeat (6) @(posedge ref_clk);
    for (int p = 0; p < 3; p++) begin
      acc(1'b1, BASE[p] + 12'h002, 32'hFF, 32'h0);
      acc(1'b0, BASE[p] + 12'h002, 32'h0, {24'h0, e[8*p +: 8] & IMPL[p]});
      chk({24'h0, altIn[p] & IMPL[p]}, {24'h0, e[8*p +: 8] & IMPL[p]});
    end
    // Edge interrupts: rising on A0, both edges on B1, then falling on A0
    extVal <= '0;
    repeat (6) @(posedge ref_clk);
    acc(1'b1, `GP_EDGE_SEL, 32'h0, 32'h0);
    acc(1'b1, `GP_IRQ_MASK, 32'h0, 32'h0);
    acc(1'b1, `GP_IRQ_STAT, 32'hFFFFFF, 32'h0);
    acc(1'b0, `GP_IRQ_STAT, 32'h0, 32'h0);
    extVal <= 24'h000201;
    repeat (6) @(posedge ref_clk);
    acc(1'b0, `GP_IRQ_STAT, 32'h0, 32'h000201);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, `GP_IRQ_MASK, 32'h1, 32'h0);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, `GP_IRQ_STAT, 32'hFFFFFF, 32'h0);
    extVal <= '0;
    repeat (6) @(posedge ref_clk);
    acc(1'b0, `GP_IRQ_STAT, 32'h0, 32'h000200);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, `GP_EDGE_SEL, 32'h1, 32'h0);
    extVal <= 24'h000001;
    repeat (6) @(posedge ref_clk);
    acc(1'b0, `GP_IRQ_STAT, 32'h0, 32'h000200);
    extVal <= '0;
    repeat (6) @(posedge ref_clk);
    acc(1'b0, `GP_IRQ_STAT, 32'h0, 32'h000201);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, `GP_IRQ_STAT, 32'h1, 32'h0);
    chk({31'h0, irq}, 32'h0);
    acc(1'b0, `GP_IRQ_STAT, 32'h0, 32'h000200);
    // Unmapped word: write ignored, reads zero
    acc(1'b1, 12'hFE3, 32'hFFFF, 32'h0);
    acc(1'b0, 12'hFE3, 32'h0, 32'h0);
    conclude();
  end
endmodule // tb_gpio_ports_indirect_config
